// File: rtl/pbm_pin_ovr.sv
/*
 * One port pin: merges the override enables and values with the
 * pin's direction and output bits into pad controls.
 * Assumes override signals come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module pbm_pin_ovr (
	input wire logic dir_bit,
	input wire logic out_bit,
	input wire logic global_pullup_disable,
	input wire logic sleep_mode,
	input wire logic pullup_ovr_en,
	input wire logic pullup_ovr_val,
	input wire logic dir_ovr_en,
	input wire logic dir_ovr_val,
	input wire logic value_ovr_en,
	input wire logic value_ovr_val,
	input wire logic input_en_ovr_en,
	input wire logic input_en_ovr_val,
	output logic pad_oe,
	output logic pad_out,
	output logic pad_pullup,
	output logic pad_input_en
);

	always_comb begin
		pad_oe = dir_ovr_en ? dir_ovr_val : dir_bit;
		pad_out = value_ovr_en ? value_ovr_val : out_bit;
		pad_pullup = pullup_ovr_en ? pullup_ovr_val
			: ({dir_bit, out_bit, global_pullup_disable} == 3'b010);
		pad_input_en = input_en_ovr_en ? input_en_ovr_val : ~sleep_mode;
	end

endmodule : pbm_pin_ovr

`default_nettype wire

// File: rtl/pbm_pkg.sv
/*
 * Constants for the port B alternate function override block:
 * register offsets, control field positions, reset values, bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package pbm_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_DIR = 8'h00;
	localparam logic [7:0] OFS_OUT = 8'h04;
	localparam logic [7:0] OFS_PIN = 8'h08;
	localparam logic [7:0] OFS_CTRL = 8'h0c;
	localparam logic [7:0] OFS_PCMASK = 8'h10;
	localparam logic [7:0] OFS_PADSTAT = 8'h14;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTRL_PULLUP_DIS = 0;
	localparam int CTRL_SERIAL_EN = 1;
	localparam int CTRL_MASTER_SEL = 2;
	localparam int CTRL_PC_GROUP = 3;
	localparam int CTRL_ASYNC = 4;
	localparam int CTRL_W = 5;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_DIR = 8'h00;
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [7:0] RST_PCMASK = 8'h00;
	localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pbm_pkg

// File: rtl/pbm_port_b.sv
/*
 * Port B alternate function override with an AXI4-Lite register slave.
 * Assumes peripherals, fuses and the sleep flag run on aclk; pad inputs
 * are asynchronous and are synchronised before the pin register reads them.
 */
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
// Function
// - Serial slave forces clock pin input; master lets direction bit decide.
// - Serial master forces master-in pin input; slave lets direction bit decide.
// - Serial slave forces master-out pin input; master lets direction bit decide.
// - Slave forces select pin input; interface active only while select low.
// - Forced-input serial pins keep pull-up from output bit and global disable.
// - Pin 3 carries timer 2 compare or serial master output when output.
// - Pin 2 carries timer 1 compare B when enabled and direction output.
// - Pin 1 carries timer 1 compare A when enabled and direction output.
// - Clock output fuse drives divided clock on pin 0, also during reset.
// - Oscillator pins 6 and 7 read zero in direction, output, input bits.
// - Pins 6 and 7 overrides come from clock fuses and async timer enable.
// - Change mask bit with group enable forces the pin's input enabled, except on pins 6 and 7 while used as oscillator pins.
// - Pin 0 raw input feeds timer 1 capture and pin-change logic.
// - Master-out pin: master output overrides value, slave input from pin.
// - Master-in pin: master input from pin, slave output overrides value.
// - Without override, pull-up only for direction, output, disable 0b010.
// - Direction override enable selects override value over direction bit.
// - Value override with driver on drives override value, not output bit.
`timescale 1ns/10ps
`default_nettype none

module pbm_port_b #(
	parameter int ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic clock_output_fuse,
	input wire logic internal_rc_selected,
	input wire logic external_clock_selected,
	input wire logic sleep_mode,
	input wire logic serial_clk_out,
	input wire logic serial_master_out,
	input wire logic serial_slave_out,
	input wire logic timer2_compare_out,
	input wire logic timer2_compare_en,
	input wire logic timer1_compare_a_out,
	input wire logic timer1_compare_a_en,
	input wire logic timer1_compare_b_out,
	input wire logic timer1_compare_b_en,
	input wire logic divided_clock_out,
	input wire logic [7:0] pad_in,
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe,
	output logic [7:0] pad_pullup,
	output logic [7:0] pad_input_en,
	output logic serial_clk_in,
	output logic serial_master_in,
	output logic serial_slave_in,
	output logic serial_select_in,
	output logic serial_slave_active,
	output logic timer1_capture_in,
	output logic [7:0] pin_change_src
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_w_check
		$error("ADDR_W outside the range the register map can serve");
	end

	// ------------------------------------------------------------
	// Registers and bus state
	// ------------------------------------------------------------
	logic [7:0] dir_bits, next_dir_bits;
	logic [7:0] out_bits, next_out_bits;
	logic [7:0] pc_mask, next_pc_mask;
	logic [pbm_pkg::CTRL_W-1:0] ctrl, next_ctrl;
	logic aw_held, next_aw_held;
	logic w_held, next_w_held;
	logic [ADDR_W-1:0] aw_addr, next_aw_addr;
	logic [7:0] w_data, next_w_data;
	logic w_lane0, next_w_lane0;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [7:0] pin_meta, pin_sync;

	logic global_pullup_disable;
	logic serial_if_enable;
	logic serial_master_select;
	logic pin_change_group_enable;
	logic async_timer_clock_sel;
	logic spi_master;
	logic spi_slave;
	logic [7:0] osc_pin;
	logic [7:0] pu_en, pu_val, dd_en, dd_val, pv_en, pv_val, die_en, die_val;
	logic [7:0] in_en;

	assign global_pullup_disable = ctrl[pbm_pkg::CTRL_PULLUP_DIS];
	assign serial_if_enable = ctrl[pbm_pkg::CTRL_SERIAL_EN];
	assign serial_master_select = ctrl[pbm_pkg::CTRL_MASTER_SEL];
	assign pin_change_group_enable = ctrl[pbm_pkg::CTRL_PC_GROUP];
	assign async_timer_clock_sel = ctrl[pbm_pkg::CTRL_ASYNC];
	assign spi_master = serial_if_enable & serial_master_select;
	assign spi_slave = serial_if_enable & ~serial_master_select;

	// ------------------------------------------------------------
	// Override tables
	// ------------------------------------------------------------
	always_comb begin
		osc_pin = 8'h00;
		osc_pin[7] = (internal_rc_selected & external_clock_selected)
			| async_timer_clock_sel;
		osc_pin[6] = internal_rc_selected | async_timer_clock_sel;
		pu_en = 8'h00;
		pu_val = 8'h00;
		dd_en = 8'h00;
		dd_val = 8'h00;
		pv_en = 8'h00;
		pv_val = 8'h00;
		die_en = pc_mask & {8{pin_change_group_enable}};
		die_val = 8'hff;
		pu_en[7:6] = osc_pin[7:6];
		dd_en[7:6] = osc_pin[7:6];
		die_en[7:6] = osc_pin[7:6] | die_en[7:6];
		die_val[7] = ~osc_pin[7] | ((internal_rc_selected | external_clock_selected)
			& async_timer_clock_sel);
		die_val[6] = ~osc_pin[6] | (internal_rc_selected & async_timer_clock_sel);
		pu_en[5] = spi_slave;
		dd_en[5] = spi_slave;
		pu_en[4] = spi_master;
		dd_en[4] = spi_master;
		pu_en[3] = spi_slave;
		dd_en[3] = spi_slave;
		pu_en[2] = spi_slave;
		dd_en[2] = spi_slave;
		pu_val[5:2] = out_bits[5:2] & ~{4{global_pullup_disable}};
		pv_en[5] = spi_master;
		pv_val[5] = serial_clk_out;
		pv_en[4] = spi_slave;
		pv_val[4] = serial_slave_out;
		// Pin 3 compare or master out
		pv_en[3] = spi_master | timer2_compare_en;
		pv_val[3] = (spi_master & serial_master_out)
			| (timer2_compare_en & timer2_compare_out);
		pv_en[2] = timer1_compare_b_en;
		pv_val[2] = timer1_compare_b_out;
		pv_en[1] = timer1_compare_a_en;
		pv_val[1] = timer1_compare_a_out;
		dd_en[0] = clock_output_fuse;
		dd_val[0] = clock_output_fuse;
		pv_en[0] = clock_output_fuse;
		pv_val[0] = divided_clock_out;
	end

	// ------------------------------------------------------------
	// Per-pin merge
	// ------------------------------------------------------------
	// Combinational pad controls
	for (genvar i = 0; i < 8; i++) begin : g_pin
		pbm_pin_ovr u_pin (
			.dir_bit(dir_bits[i]),
			.out_bit(out_bits[i]),
			.global_pullup_disable(global_pullup_disable),
			.sleep_mode(sleep_mode),
			.pullup_ovr_en(pu_en[i]),
			.pullup_ovr_val(pu_val[i]),
			.dir_ovr_en(dd_en[i]),
			.dir_ovr_val(dd_val[i]),
			.value_ovr_en(pv_en[i]),
			.value_ovr_val(pv_val[i]),
			.input_en_ovr_en(die_en[i]),
			.input_en_ovr_val(die_val[i]),
			.pad_oe(pad_oe[i]),
			.pad_out(pad_out[i]),
			.pad_pullup(pad_pullup[i]),
			.pad_input_en(in_en[i])
		);
	end

	assign pad_input_en = in_en;

	// ------------------------------------------------------------
	// Digital inputs to peripherals
	// ------------------------------------------------------------
	always_comb begin
		pin_change_src = pad_in & in_en;
		serial_clk_in = pin_change_src[5];
		serial_master_in = pin_change_src[4];
		serial_slave_in = pin_change_src[3];
		serial_select_in = pin_change_src[2];
		serial_slave_active = spi_slave & ~pad_in[2];
		timer1_capture_in = pin_change_src[0];
	end

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	function automatic logic [31:0] read_word(input logic [7:0] ofs,
			input logic [7:0] dirv, input logic [7:0] outv,
			input logic [7:0] pinv, input logic [7:0] pcm,
			input logic [pbm_pkg::CTRL_W-1:0] ctl, input logic [7:0] mask,
			input logic [7:0] oe);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (ofs)
			pbm_pkg::OFS_DIR: w[7:0] = dirv & ~mask;
			pbm_pkg::OFS_OUT: w[7:0] = outv & ~mask;
			pbm_pkg::OFS_PIN: w[7:0] = pinv & ~mask;
			pbm_pkg::OFS_CTRL: w[pbm_pkg::CTRL_W-1:0] = ctl;
			pbm_pkg::OFS_PCMASK: w[7:0] = pcm;
			pbm_pkg::OFS_PADSTAT: w[7:0] = oe;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : read_word

	function automatic logic mapped(input logic [7:0] ofs);
		return ofs == pbm_pkg::OFS_DIR || ofs == pbm_pkg::OFS_OUT
			|| ofs == pbm_pkg::OFS_PIN || ofs == pbm_pkg::OFS_CTRL
			|| ofs == pbm_pkg::OFS_PCMASK || ofs == pbm_pkg::OFS_PADSTAT;
	endfunction : mapped

	logic [7:0] wofs, rofs;
	logic do_write;

	always_comb begin
		wofs = 8'(aw_addr);
		rofs = 8'(s_axi_araddr);
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rresp = rresp;
		next_rdata = rdata;
		next_dir_bits = dir_bits;
		next_out_bits = out_bits;
		next_pc_mask = pc_mask;
		next_ctrl = ctrl;
		if (s_axi_awvalid && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		do_write = aw_held && w_held && !bvalid;
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (mapped(wofs) && wofs[1:0] == 2'h0) ? pbm_pkg::RESP_OKAY
				: pbm_pkg::RESP_SLVERR;
			if (w_lane0 && wofs[1:0] == 2'h0) begin
				unique case (wofs)
					pbm_pkg::OFS_DIR: next_dir_bits = w_data;
					pbm_pkg::OFS_OUT: next_out_bits = w_data;
					pbm_pkg::OFS_PCMASK: next_pc_mask = w_data;
					pbm_pkg::OFS_CTRL: next_ctrl = w_data[pbm_pkg::CTRL_W-1:0];
					default: next_ctrl = ctrl;
				endcase
			end
		end else if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rdata = read_word(rofs, dir_bits, out_bits, pin_sync, pc_mask,
				ctrl, osc_pin, pad_oe);
			next_rresp = (mapped(rofs) && rofs[1:0] == 2'h0) ? pbm_pkg::RESP_OKAY
				: pbm_pkg::RESP_SLVERR;
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_bits <= pbm_pkg::RST_DIR;
			out_bits <= pbm_pkg::RST_OUT;
			pc_mask <= pbm_pkg::RST_PCMASK;
			ctrl <= pbm_pkg::RST_CTRL;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
			bvalid <= 1'b0;
			bresp <= pbm_pkg::RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= pbm_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			dir_bits <= next_dir_bits;
			out_bits <= next_out_bits;
			pc_mask <= next_pc_mask;
			ctrl <= next_ctrl;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			pin_meta <= pad_in;
			pin_sync <= pin_meta;
		end
	end

	always_comb begin
		s_axi_awready = ~aw_held;
		s_axi_wready = ~w_held;
		s_axi_bvalid = bvalid;
		s_axi_bresp = bresp;
		s_axi_arready = ~rvalid;
		s_axi_rvalid = rvalid;
		s_axi_rresp = rresp;
		s_axi_rdata = rdata;
	end

endmodule : pbm_port_b

`default_nettype wire

// File: sim/pbm_periph.sv
/* Stand-in for serial, timer and clock peripherals.
   Outputs follow a pattern word from the bench, except the divided clock, which toggles on each rising aclk edge. */
`timescale 1ns/10ps
`default_nettype none
module pbm_periph (
	input wire logic aclk,
	input wire logic [8:0] drv,
	output logic serial_clk_out,
	output logic serial_master_out,
	output logic serial_slave_out,
	output logic timer2_compare_en,
	output logic timer2_compare_out,
	output logic timer1_compare_a_en,
	output logic timer1_compare_a_out,
	output logic timer1_compare_b_en,
	output logic timer1_compare_b_out,
	output var logic divided_clock_out
);
	assign {serial_slave_out, serial_master_out, serial_clk_out} = drv[2:0];
	assign {timer2_compare_en, timer2_compare_out} = {drv[3], drv[3] & drv[4]};
	assign {timer1_compare_a_en, timer1_compare_a_out} = {drv[5], drv[5] & drv[6]};
	assign {timer1_compare_b_en, timer1_compare_b_out} = {drv[7], drv[7] & drv[8]};
	initial divided_clock_out = 1'b0;
	always @(posedge aclk) divided_clock_out <= ~divided_clock_out;
endmodule : pbm_periph
`default_nettype wire

// File: sim/pbm_sva.sv
/* Assertion checker for pbm_port_b.
   Bound to the block; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module pbm_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic clock_output_fuse,
	input wire logic internal_rc_selected,
	input wire logic external_clock_selected,
	input wire logic divided_clock_out,
	input wire logic [7:0] pad_in,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] pad_oe,
	input wire logic [7:0] pad_pullup,
	input wire logic [7:0] pad_input_en,
	input wire logic serial_slave_in,
	input wire logic serial_slave_active,
	input wire logic timer1_capture_in,
	input wire logic [7:0] pin_change_src
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	clk_out_a: assert property (
		clock_output_fuse |-> pad_oe[0] && pad_out[0] == divided_clock_out)
		else $error("clock out");
	clk_reset_a: assert property (disable iff (1'b0)
		!aresetn && clock_output_fuse |-> pad_oe[0] && pad_out[0] == divided_clock_out)
		else $error("clock out in reset");
	capture_path_a: assert property (
		timer1_capture_in == (pad_in[0] & pad_input_en[0])) else $error("capture");
	change_src_a: assert property (
		pin_change_src == (pad_in & pad_input_en)) else $error("pin change");
	slave_in_a: assert property (
		serial_slave_in == (pad_in[3] & pad_input_en[3])) else $error("slave in");
	slave_sel_a: assert property (
		serial_slave_active |-> !pad_in[2] && !pad_oe[2]) else $error("select");
	osc_six_a: assert property (
		internal_rc_selected |-> !pad_oe[6] && !pad_pullup[6]) else $error("pin 6");
	osc_seven_a: assert property (
		internal_rc_selected && external_clock_selected |-> !pad_oe[7] && !pad_pullup[7])
		else $error("pin 7");
	write_answer_a: assert property (
		wr_taken |=> wr_answer) else $error("bvalid");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("rvalid");
endmodule : pbm_sva
bind pbm_port_b pbm_sva chk_u (.*);
`default_nettype wire

// File: sim/tb.sv
/* Bench for pbm_port_b: bus master, pads and peripheral pattern.
   Assumes pbm_periph for the peripherals. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pad_in = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic clock_output_fuse = 1'b0, internal_rc_selected = 1'b0;
	logic external_clock_selected = 1'b0, sleep_mode = 1'b0;
	logic serial_clk_out, serial_master_out, serial_slave_out, divided_clock_out;
	logic timer2_compare_en, timer2_compare_out, timer1_compare_a_en;
	logic timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out;
	logic [7:0] pad_out, pad_oe, pad_pullup, pad_input_en, pin_change_src, eoe, eosc, epin;
	logic serial_clk_in, serial_master_in, serial_slave_in, serial_select_in;
	logic serial_slave_active, timer1_capture_in;
	logic [8:0] drv = 9'h000;
	logic [33:0] epad, seen, rq[$];
	logic [31:0] rng = 32'h4c18;
	int err_count = 0, tests_run = 0, cyc = 0;
	always #10 aclk = ~aclk;
	pbm_port_b dut_u (.*);
	pbm_periph per_u (.*);
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// ------------------------------
	// Answers and run limit
	// ------------------------------
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_rvalid === 1'b1)
			chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid === 1'b1)
			chk("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
		if (cyc == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
	endtask : rd
	task automatic model(input logic [7:0] d, o, m, input logic [4:0] c);
		logic slv, mst;
		logic [7:0] fin, pv, pvv, eie, epu;
		slv = c[1] & ~c[2];
		mst = c[1] & c[2];
		eosc = {(internal_rc_selected & external_clock_selected) | c[4],
			internal_rc_selected | c[4], 6'h00};
		fin = eosc | {2'b00, slv, mst, slv, slv, 2'b00};
		eoe = d & ~fin;
		epu = (~d | fin) & o & ~{8{c[0]}} & ~eosc;
		pv = {2'b00, mst, slv, mst | drv[3], drv[7], drv[5], 1'b0};
		pvv = {2'b00, drv[0], drv[2], (mst & drv[1]) | (drv[3] & drv[4]), drv[8], drv[6], 1'b0};
		eie = (m & {8{c[3]}}) | ~{8{sleep_mode}};
		eie[7] = eosc[7] ? (internal_rc_selected | external_clock_selected) & c[4] : eie[7];
		eie[6] = eosc[6] ? internal_rc_selected & c[4] : eie[6];
		epin = pad_in & eie;
		epad = {1'b0, slv & ~pad_in[2], eoe, epu, eie, (pv & pvv | ~pv & o) & eoe};
	endtask : model
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		logic [7:0] d, o, m;
		logic [4:0] c;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), 34'h0);
		rd(8'h18, {2'h2, 32'h0});
		wr(8'h1c, 32'hff, 2'h2);
		for (int n = 0; n < 40; n++) begin
			rng = xs(rng);
			{c, m, o, d} = rng[28:0];
			rng = xs(rng);
			// Master output idles low unless master
			drv <= {rng[8:2], rng[1] & c[1] & c[2], rng[0]};
			pad_in <= rng[16:9];
			{sleep_mode, internal_rc_selected, external_clock_selected} <= rng[19:17];
			wr(8'h00, {24'h0, d});
			wr(8'h04, {24'h0, o});
			wr(8'h0c, {27'h0, c});
			wr(8'h10, {24'h0, m});
			@(negedge aclk);
			model(d, o, m, c);
			seen = {1'b0, serial_slave_active, pad_oe, pad_pullup, pad_input_en, 8'h00};
			seen[7:0] = pad_out & pad_oe;
			chk("pads", seen, epad);
			seen = {21'h0, serial_clk_in, serial_master_in, serial_slave_in, serial_select_in,
				timer1_capture_in, pin_change_src};
			chk("inputs", seen, {21'h0, epin[5:2], epin[0], epin});
			@(posedge aclk);
			rd(8'h00, {26'h0, d & ~eosc});
			rd(8'h04, {26'h0, o & ~eosc});
			rd(8'h08, {26'h0, pad_in & ~eosc});
			rd(8'h0c, {29'h0, c});
			rd(8'h14, {26'h0, eoe});
		end
		clock_output_fuse <= 1'b1;
		aresetn <= 1'b0;
		repeat (3) begin
			@(negedge aclk);
			chk("clock_out", {32'h0, pad_out[0], pad_oe[0]}, {32'h0, divided_clock_out, 1'b1});
		end
		@(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h14, 34'h1);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
